// File: core/deep_sleep_pkg.sv
/*
 * constants and carrier types for the deep sleep power control block.
 * assumes a single 200 MHz clock and an active-low mode-set pin from the host.
 */
`default_nettype none
package deep_sleep_pkg;
    // clock period in picoseconds (200 MHz)
    localparam int unsigned CLK_PERIOD_PS        = 5000;
    // longest mode-set low time that still counts as normal operation, in ns
    localparam int unsigned MODE_SET_LOW_MAX_NS  = 500;
    // the same figure as clock cycles (longest time, rounded down)
    localparam int unsigned MODE_SET_LOW_CYCLES  = (MODE_SET_LOW_MAX_NS * 1000) / CLK_PERIOD_PS;
    // width of the low-time counter
    localparam int unsigned LOW_CNT_W            = 8;
    // default deep sleep enable bit of the mode register
    localparam logic        DEEP_SLEEP_EN_RESET  = 1'b1;
    // default of the remaining mode register settings
    localparam logic [7:0]  MODE_CFG_RESET       = 8'h00;

    // power states of the block
    typedef enum logic [1:0] {
        PWR_NORMAL,
        PWR_DEEP_SLEEP
    } pwr_state_t;

    // mode register image held by the block
    typedef struct packed {
        logic       deep_sleep_en;
        logic [7:0] cfg;
    } mode_reg_t;
endpackage
`default_nettype wire

// File: core/deep_sleep_power_control.sv
/*
 * deep sleep power control for a pseudo-static ram core.
 * - watches the low-active mode-set pin and times each low period in normal operation
 * - a low held beyond the threshold, with deep sleep enabled in the
 *   mode register, executes the deep sleep state
 * - in the executed state refresh is stopped and the array contents are
 *   flagged as lost; the flag stays up until the next reset
 * - a wake-up sequence from the host leaves the state and reloads every
 *   mode register setting with its default
 * - a short low, or a low with the enable clear, changes nothing
 * - the threshold is a count of clock cycles; a low of exactly the
 *   threshold length is still normal operation
 * - writes to the mode register are refused while asleep
 * assumes:
 * - the mode-set pin and the wake-up indication are asynchronous to CLK
 *   and pass two flops before any logic reads them
 * - mode writes are one-cycle strobes from logic on CLK
 * - RST_N is asynchronous and is released through two flops here
 * - the host rewrites the mode register after every wake-up
 */
`default_nettype none
module deep_sleep_power_control (
    input  wire logic                    CLK,
    input  wire logic                    RST_N,
    input  wire logic                    MODE_SET_PIN_N,
    input  wire logic                    WAKE_SEQ,
    input  wire logic                    MODE_WR,
    input  wire deep_sleep_pkg::mode_reg_t MODE_WDATA,
    output var  deep_sleep_pkg::mode_reg_t MODE_REG,
    output var  logic                    REFRESH_EN,
    output var  logic                    DEEP_SLEEP_STATE,
    output var  logic                    DATA_CORRUPT
);
    // reset release synchroniser
    logic                                 rst_meta;        // first stage of the release
    logic                                 rst_sync_n;      // internal reset, low active

    // mode-set pin synchroniser
    logic                                 pin_meta;        // first stage, read by pin_sync only
    logic                                 pin_sync;        // settled pin level, low active
    logic                                 next_pin_meta;   // next first stage
    logic                                 next_pin_sync;   // next settled level

    // wake-up synchroniser
    logic                                 wake_meta;       // first stage, read by wake_sync only
    logic                                 wake_sync;       // settled wake-up indication
    logic                                 next_wake_meta;  // next first stage
    logic                                 next_wake_sync;  // next settled indication

    // power state
    deep_sleep_pkg::pwr_state_t           state;           // normal or executed deep sleep
    deep_sleep_pkg::pwr_state_t           next_state;      // state after this edge

    // low-time counter
    logic [deep_sleep_pkg::LOW_CNT_W-1:0] low_cnt;         // synchronised low cycles so far
    logic [deep_sleep_pkg::LOW_CNT_W-1:0] next_low_cnt;    // count after this edge

    // next values of the registered outputs
    deep_sleep_pkg::mode_reg_t            next_mode_reg;   // mode register image
    logic                                 next_refresh_en; // refresh request
    logic                                 next_deep_sleep; // executed state flag
    logic                                 next_corrupt;    // contents lost flag

    // decoded conditions
    logic                                 low_seen;        // pin held low this cycle
    logic                                 low_expired;     // low lasted the full threshold
    logic                                 enter_sleep;     // execute deep sleep at this edge

    // default mode register image, loaded on the way out of deep sleep;
    // built from the same constants as the reset value so the two agree
    function automatic deep_sleep_pkg::mode_reg_t mode_default();
        deep_sleep_pkg::mode_reg_t m;
        m.deep_sleep_en = deep_sleep_pkg::DEEP_SLEEP_EN_RESET;
        m.cfg           = deep_sleep_pkg::MODE_CFG_RESET;
        return m;
    endfunction

    // true once a low count has reached the threshold; the cast keeps the
    // compare at counter width
    function automatic logic low_time_over(
        input logic [deep_sleep_pkg::LOW_CNT_W-1:0] cnt
    );
        return (cnt >= deep_sleep_pkg::LOW_CNT_W'(deep_sleep_pkg::MODE_SET_LOW_CYCLES));
    endfunction

    // reset is released through two flops; assertion stays asynchronous
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            rst_meta   <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            // ones walk in from the first stage
            rst_meta   <= 1'b1;
            rst_sync_n <= rst_meta;
        end
    end

    // next values of the pin synchronisers
    always_comb begin
        next_pin_meta  = MODE_SET_PIN_N;
        next_pin_sync  = pin_meta;
        next_wake_meta = WAKE_SEQ;
        next_wake_sync = wake_meta;
    end

    // two-flop synchronisers; idle levels are pin high and no wake-up, so
    // no false low or false wake follows reset
    always_ff @(posedge CLK or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            pin_meta  <= 1'b1;
            pin_sync  <= 1'b1;
            wake_meta <= 1'b0;
            wake_sync <= 1'b0;
        end else begin
            pin_meta  <= next_pin_meta;
            pin_sync  <= next_pin_sync;
            wake_meta <= next_wake_meta;
            wake_sync <= next_wake_sync;
        end
    end

    // decoded conditions of the normal state
    assign low_seen    = !pin_sync;
    assign low_expired = low_time_over(low_cnt);
    // a long low only executes deep sleep while the enable bit is set
    assign enter_sleep = (state == deep_sleep_pkg::PWR_NORMAL) && low_seen &&
                         low_expired && MODE_REG.deep_sleep_en;

    // low-time counter: counts synchronised low cycles in normal operation.
    // it saturates at the threshold, so a low of any length cannot wrap
    // round and look short again.
    always_comb begin
        next_low_cnt = low_cnt;
        if (state != deep_sleep_pkg::PWR_NORMAL) begin
            // nothing is timed while asleep
            next_low_cnt = '0;
        end else if (!low_seen) begin
            // a high restarts the count, so short lows never add up
            next_low_cnt = '0;
        end else if (enter_sleep) begin
            // the count is spent on the entry
            next_low_cnt = '0;
        end else if (!low_expired) begin
            next_low_cnt = low_cnt + 1'b1;
        end
    end

    // low-time counter register
    always_ff @(posedge CLK or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            low_cnt <= '0;
        end else begin
            low_cnt <= next_low_cnt;
        end
    end

    // next power state, mode register and output flags.
    // timing from a pin going low: two edges of synchroniser, the threshold
    // count, then one edge to register the new state. the outputs are
    // computed from the next state so that they change together with it.
    always_comb begin
        // hold everything unless a branch below says otherwise
        next_state    = state;
        next_mode_reg = MODE_REG;
        next_corrupt  = DATA_CORRUPT;
        unique case (state)
            deep_sleep_pkg::PWR_NORMAL: begin
                if (enter_sleep) begin
                    // long low while enabled: execute deep sleep
                    next_state   = deep_sleep_pkg::PWR_DEEP_SLEEP;
                    // array contents are lost from here on; the flag is sticky
                    next_corrupt = 1'b1;
                end else if (MODE_WR) begin
                    // a write changes settings only; refresh keeps running
                    next_mode_reg = MODE_WDATA;
                end
            end
            deep_sleep_pkg::PWR_DEEP_SLEEP: begin
                // writes are ignored; stay until the wake-up sequence arrives
                if (wake_sync) begin
                    next_state    = deep_sleep_pkg::PWR_NORMAL;
                    // every setting returns to its default on the way out
                    next_mode_reg = mode_default();
                end
            end
            default: begin
                // an illegal code falls back to normal operation
                next_state = deep_sleep_pkg::PWR_NORMAL;
            end
        endcase
        next_deep_sleep = (next_state == deep_sleep_pkg::PWR_DEEP_SLEEP);
        // refresh stops only in the executed state, never from the enable bit
        next_refresh_en = !next_deep_sleep;
    end

    // registered outputs and power state; reset gives normal operation with
    // every mode setting at its default
    always_ff @(posedge CLK or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            state            <= deep_sleep_pkg::PWR_NORMAL;
            MODE_REG         <= '{deep_sleep_en: deep_sleep_pkg::DEEP_SLEEP_EN_RESET,
                                  cfg: deep_sleep_pkg::MODE_CFG_RESET};
            REFRESH_EN       <= 1'b1;
            DEEP_SLEEP_STATE <= 1'b0;
            DATA_CORRUPT     <= 1'b0;
        end else begin
            // every top-level output comes straight from one of these flops
            state            <= next_state;
            MODE_REG         <= next_mode_reg;
            REFRESH_EN       <= next_refresh_en;
            DEEP_SLEEP_STATE <= next_deep_sleep;
            DATA_CORRUPT     <= next_corrupt;
        end
    end
endmodule
`default_nettype wire

// File: test/deep_sleep_checker.sv
/* checks deep sleep control at its ports; bound to the control block */
`default_nettype none
module deep_sleep_checker (
    input wire logic                      CLK,
    input wire logic                      RST_N,
    input wire logic                      MODE_SET_PIN_N,
    input wire logic                      WAKE_SEQ,
    input wire deep_sleep_pkg::mode_reg_t MODE_REG,
    input wire logic                      REFRESH_EN,
    input wire logic                      DEEP_SLEEP_STATE,
    input wire logic                      DATA_CORRUPT
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [8:0] low_run; // edges the pin was seen low in a row
    always_ff @(posedge CLK or negedge RST_N)
        if (!RST_N) low_run <= 9'h0;
        else low_run <= MODE_SET_PIN_N ? 9'h0 : low_run + {8'h0, low_run != 9'h1ff};
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RST_N);
    chk_refresh_off: assert property (DEEP_SLEEP_STATE |-> !REFRESH_EN)
        else $error("refresh running asleep");
    chk_refresh_on: assert property (!DEEP_SLEEP_STATE |-> REFRESH_EN)
        else $error("refresh stopped awake");
    chk_corrupt_set: assert property ($rose(DEEP_SLEEP_STATE) |-> DATA_CORRUPT)
        else $error("entry without data loss flag");
    chk_short_low: assert property ($rose(DEEP_SLEEP_STATE) |->
        $past(low_run, 2) > 9'(deep_sleep_pkg::MODE_SET_LOW_CYCLES))
        else $error("entry on a short low");
    chk_long_low: assert property (low_run == 9'(deep_sleep_pkg::MODE_SET_LOW_CYCLES + 3) &&
        MODE_REG.deep_sleep_en |-> DEEP_SLEEP_STATE)
        else $error("no entry on a long low");
    chk_wake_only: assert property ($fell(DEEP_SLEEP_STATE) |-> $past(WAKE_SEQ, 3))
        else $error("exit without wake");
    chk_stay_asleep: assert property (DEEP_SLEEP_STATE && !$past(WAKE_SEQ, 2) |=> DEEP_SLEEP_STATE)
        else $error("left sleep early");
    chk_exit_dflt: assert property ($fell(DEEP_SLEEP_STATE) |-> MODE_REG == 9'h100)
        else $error("mode not default on exit");
    cover property ($rose(DEEP_SLEEP_STATE));
    cover property ($fell(DEEP_SLEEP_STATE));
    cover property (low_run == 9'h63);
endmodule
`default_nettype wire

// File: test/host_model.sv
/* host side: drives mode-set lows and wake-up; clock comes from the bench */
`default_nettype none
module host_model (
    input  wire logic        clk,
    input  wire logic [15:0] low_len,
    input  wire logic        wake_req,
    output var  logic        pin_n,
    output var  logic        wake
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [15:0] cnt = 16'h0; // low cycles left
    logic [2:0]  wcnt = 3'h0; // wake cycles left
    always_ff @(posedge clk) begin
        cnt <= (low_len != 16'h0) ? low_len : cnt - {15'h0, cnt != 16'h0};
        wcnt <= wake_req ? 3'h4 : wcnt - {2'h0, wcnt != 3'h0};
    end
    assign pin_n = (cnt == 16'h0);
    assign wake = (wcnt != 3'h0);
endmodule
`default_nettype wire

// File: test/tb_top.sv
/* bench for deep sleep control; assumes the host model and the checker */
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic CLK = 1'b0, RST_N = 1'b0, MODE_WR = 1'b0, wake_req = 1'b0;
    logic [15:0] low_len = 16'h0;
    deep_sleep_pkg::mode_reg_t MODE_WDATA = '0, MODE_REG;
    logic MODE_SET_PIN_N, WAKE_SEQ, REFRESH_EN, DEEP_SLEEP_STATE, DATA_CORRUPT;
    wire logic [8:0] seen = {6'h0, REFRESH_EN, DEEP_SLEEP_STATE, DATA_CORRUPT};
    int fail_count = 0, total_checks = 0, cyc = 0, seed = 48, n = 0;
    logic [8:0] d;
    always #2.5 CLK = ~CLK;
    always @(posedge CLK) if (++cyc == 3000) begin
        fail_count++;
        print_verdict();
    end
    deep_sleep_power_control dut_u (.CLK, .RST_N, .MODE_SET_PIN_N, .WAKE_SEQ, .MODE_WR,
        .MODE_WDATA, .MODE_REG, .REFRESH_EN, .DEEP_SLEEP_STATE, .DATA_CORRUPT);
    host_model host_u (.clk(CLK), .low_len, .wake_req, .pin_n(MODE_SET_PIN_N), .wake(WAKE_SEQ));
    task automatic chk(input string nm, input logic [8:0] e, g);
        total_checks++;
        if (g !== e) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    function automatic logic [8:0] st(input logic s, c);
        return {6'h0, !s, s, c};
    endfunction
    task automatic step(input int n);
        repeat (n) @(posedge CLK);
        #1;
    endtask
    task automatic wr_reg(input logic [8:0] v);
        MODE_WR = 1'b1;
        MODE_WDATA = v;
        step(1);
        MODE_WR = 1'b0;
    endtask
    task automatic low(input int n);
        low_len = 16'(n);
        step(1);
        low_len = 16'h0;
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        step(10);
        RST_N = 1'b1;
        step(3);
        chk("mode", 9'h100, MODE_REG);
        for (int i = 0; i < 6; i++) begin
            d = {1'b1, 8'($random(seed))};
            wr_reg(d);
            chk("mode", d, MODE_REG);
            low(i == 0 ? 100 : 1 + {$random(seed)} % 100);
            step(110);
            chk("state", st(0, 0), seen);
        end
        wr_reg(9'h05a);
        low(300);
        step(310);
        chk("state", st(0, 0), seen);
        wr_reg(9'h1a5);
        low(400);
        for (n = 0; n < 150 && DEEP_SLEEP_STATE !== 1'b1; n++) step(1);
        chk("entry", 9'(deep_sleep_pkg::MODE_SET_LOW_CYCLES + 3), 9'(n));
        chk("state", st(1, 1), seen);
        wr_reg(9'h0ff);
        step(300);
        chk("mode", 9'h1a5, MODE_REG);
        chk("state", st(1, 1), seen);
        wake_req = 1'b1;
        step(1);
        wake_req = 1'b0;
        step(6);
        chk("mode", 9'h100, MODE_REG);
        chk("state", st(0, 1), seen);
        wr_reg(9'h133);
        chk("mode", 9'h133, MODE_REG);
        chk("state", st(0, 1), seen);
        RST_N = 1'b0;
        step(2);
        RST_N = 1'b1;
        step(3);
        chk("mode", 9'h100, MODE_REG);
        chk("state", st(0, 0), seen);
        print_verdict();
    end
endmodule
bind deep_sleep_power_control deep_sleep_checker chk_u (.CLK, .RST_N, .MODE_SET_PIN_N,
    .WAKE_SEQ, .MODE_REG, .REFRESH_EN, .DEEP_SLEEP_STATE, .DATA_CORRUPT);
`default_nettype wire
